// >>> logic/xsd_pkg.sv
// package: opcodes, phase states, field positions and reset values
// for the xor / nibble swap / direction load execute block
// assumes one core clock, one phase per clock edge
package xsd_pkg;
   // instruction word layout (14 bits)
   localparam int          INSN_W       = 14;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 7;
   localparam int          DEST_BIT     = 7;
   localparam int          OP6_HI       = 13;
   localparam int          OP6_LO       = 8;
   localparam int          DIR_SEL_HI   = 2;
   // opcode patterns in bits 13:8
   localparam logic [5:0]  XOR_LIT_OP6  = 6'h3a;
   localparam logic [5:0]  XOR_FILE_OP6 = 6'h06;
   localparam logic [5:0]  SWAP_OP6     = 6'h0e;
   // direction load: bits 13:3 fixed pattern, then 3-bit select
   localparam logic [10:0] DIR_LOAD_PAT = 11'h00c;
   localparam logic [2:0]  DIR_SEL_MIN  = 3'h5;
   localparam logic [2:0]  DIR_SEL_MAX  = 3'h7;
   // file addresses of the three direction registers
   localparam logic [6:0]  DIR_ADDR_BASE = 7'h05;
   localparam logic [6:0]  DIR_ADDR_5   = 7'h05;
   localparam logic [6:0]  DIR_ADDR_7   = 7'h07;
   // reset values
   localparam logic [7:0]  W_RESET      = 8'h00;
   localparam logic [7:0]  DIR_RESET    = 8'hff;
   localparam logic        ZERO_RESET   = 1'b0;
   // four phases of one instruction cycle, gray order
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b11,
      PH_WRITE   = 2'b10
   } phase_t;
   // decoded operation
   typedef enum logic [2:0] {
      OP_NONE     = 3'h0,
      OP_XOR_LIT  = 3'h1,
      OP_XOR_FILE = 3'h2,
      OP_SWAP     = 3'h3,
      OP_DIR_LOAD = 3'h4
   } op_t;
endpackage

// >>> logic/xor_swap_direction_load_op_exec.sv
// execute block for literal xor, file xor, nibble swap, direction load
// assumes an outside register file answering reads combinationally
// in the read phase and taking one write pulse in the decode phase after the write phase
`timescale 1ns/10ps
module xor_swap_direction_load_op_exec (
   input  wire logic        clk,          // core clock, one phase per edge
   input  wire logic        sys_rst,      // async reset, active high
   input  wire logic [13:0] insn,         // instruction word, held all cycle
   input  wire logic [7:0]  file_rdata,   // outside register file read data
   output logic             phase_start,  // high in decode phase
   output logic [6:0]       file_addr,    // file register address
   output logic             file_re,      // read strobe, read phase
   output logic             file_we,      // write strobe, decode phase after write
   output logic [7:0]       file_wdata,   // write data
   output logic [7:0]       w_reg,        // working register
   output logic             zero_flag,    // zero status flag
   output logic             zero_we,      // pulse when zero flag updated
   output logic [7:0]       dir5,         // direction register 5
   output logic [7:0]       dir6,         // direction register 6
   output logic [7:0]       dir7          // direction register 7
);

////////////////////////////////////////////////////////////////////////
// decode helpers

   // classify an instruction word
   function automatic xsd_pkg::op_t decode_op(input logic [13:0] i);
      logic [5:0] op6;
      op6 = i[xsd_pkg::OP6_HI:xsd_pkg::OP6_LO];
      if (op6 == xsd_pkg::XOR_LIT_OP6)
         decode_op = xsd_pkg::OP_XOR_LIT;
      else if (op6 == xsd_pkg::XOR_FILE_OP6)
         decode_op = xsd_pkg::OP_XOR_FILE;
      else if (op6 == xsd_pkg::SWAP_OP6)
         decode_op = xsd_pkg::OP_SWAP;
      else if (i[13:3] == xsd_pkg::DIR_LOAD_PAT &&
               i[2:0] >= xsd_pkg::DIR_SEL_MIN)
         decode_op = xsd_pkg::OP_DIR_LOAD;
      else
         decode_op = xsd_pkg::OP_NONE;
   endfunction

   // true when an address hits a direction register
   function automatic logic is_dir(input logic [6:0] a);
      is_dir = (a >= xsd_pkg::DIR_ADDR_5) && (a <= xsd_pkg::DIR_ADDR_7);
   endfunction

////////////////////////////////////////////////////////////////////////
// state

   xsd_pkg::phase_t phase, next_phase;     // current phase
   xsd_pkg::op_t    op, next_op;           // latched operation
   logic [7:0]      operand, next_operand; // literal or read value
   logic [7:0]      result, next_result;   // processed value
   logic            dest, next_dest;       // destination bit
   logic [6:0]      next_file_addr;
   logic            next_file_re;
   logic            next_file_we;
   logic [7:0]      next_file_wdata;
   logic [7:0]      next_w_reg;
   logic            next_zero_flag;
   logic            next_zero_we;
   logic [7:0]      next_dir5, next_dir6, next_dir7;
   logic            next_phase_start;
   logic [7:0]      rdata_mux;             // read data incl. direction regs
   logic [2:0]      dsel;                  // direction select index

////////////////////////////////////////////////////////////////////////
// next state

   // one process sequences the four phases and computes all outputs
   always_comb begin
      next_phase       = phase;
      next_op          = op;
      next_operand     = operand;
      next_result      = result;
      next_dest        = dest;
      next_file_addr   = file_addr;
      next_file_re     = 1'b0;
      next_file_we     = 1'b0;
      next_file_wdata  = file_wdata;
      next_w_reg       = w_reg;
      next_zero_flag   = zero_flag;
      next_zero_we     = 1'b0;
      next_dir5        = dir5;
      next_dir6        = dir6;
      next_dir7        = dir7;
      next_phase_start = 1'b0;
      dsel             = insn[xsd_pkg::DIR_SEL_HI:0];
      // direction registers answer reads by address
      case (file_addr)
         xsd_pkg::DIR_ADDR_5: rdata_mux = dir5;
         xsd_pkg::DIR_ADDR_BASE + 7'h01:
                              rdata_mux = dir6;      // middle register
         xsd_pkg::DIR_ADDR_7: rdata_mux = dir7;
         default:             rdata_mux = file_rdata;
      endcase
      case (phase)
         xsd_pkg::PH_DECODE: begin
            next_op        = decode_op(insn);
            next_dest      = insn[xsd_pkg::DEST_BIT];
            next_file_addr = insn[6:0];
            next_phase     = xsd_pkg::PH_READ;
            // read strobe in next phase for file operations
            next_file_re   = (decode_op(insn) == xsd_pkg::OP_XOR_FILE) ||
                             (decode_op(insn) == xsd_pkg::OP_SWAP);
         end
         xsd_pkg::PH_READ: begin
            if (op == xsd_pkg::OP_XOR_LIT)
               next_operand = insn[7:0];
            else
               next_operand = rdata_mux;
            next_phase = xsd_pkg::PH_PROCESS;
         end
         xsd_pkg::PH_PROCESS: begin
            case (op)
               xsd_pkg::OP_XOR_LIT,
               xsd_pkg::OP_XOR_FILE:
                  next_result = w_reg ^ operand;
               xsd_pkg::OP_SWAP:
                  next_result = {operand[3:0], operand[7:4]};
               default:
                  next_result = w_reg;
            endcase
            next_phase = xsd_pkg::PH_WRITE;
         end
         xsd_pkg::PH_WRITE: begin
            case (op)
               xsd_pkg::OP_XOR_LIT: begin
                  next_w_reg     = result;
                  next_zero_flag = (result == 8'h00);
                  next_zero_we   = 1'b1;
               end
               xsd_pkg::OP_XOR_FILE,
               xsd_pkg::OP_SWAP: begin
                  if (!dest)
                     next_w_reg = result;
                  else if (is_dir(file_addr)) begin
                     if (file_addr == xsd_pkg::DIR_ADDR_5)
                        next_dir5 = result;
                     else if (file_addr == xsd_pkg::DIR_ADDR_7)
                        next_dir7 = result;
                     else
                        next_dir6 = result;
                  end else begin
                     next_file_we    = 1'b1;
                     next_file_wdata = result;
                  end
                  // xor updates zero; swap leaves flags alone
                  if (op == xsd_pkg::OP_XOR_FILE) begin
                     next_zero_flag = (result == 8'h00);
                     next_zero_we   = 1'b1;
                  end
               end
               xsd_pkg::OP_DIR_LOAD: begin
                  if (dsel == xsd_pkg::DIR_SEL_MIN)
                     next_dir5 = result;
                  else if (dsel == xsd_pkg::DIR_SEL_MAX)
                     next_dir7 = result;
                  else
                     next_dir6 = result;
               end
               default: ;                                    // no effect
            endcase
            next_phase       = xsd_pkg::PH_DECODE;
            next_phase_start = 1'b1;
         end
         default: next_phase = xsd_pkg::PH_DECODE;
      endcase
   end

////////////////////////////////////////////////////////////////////////
// registers

   // registers only; reset loads constants
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase       <= xsd_pkg::PH_DECODE;
         op          <= xsd_pkg::OP_NONE;
         operand     <= 8'h00;
         result      <= 8'h00;
         dest        <= 1'b0;
         file_addr   <= 7'h00;
         file_re     <= 1'b0;
         file_we     <= 1'b0;
         file_wdata  <= 8'h00;
         w_reg       <= xsd_pkg::W_RESET;
         zero_flag   <= xsd_pkg::ZERO_RESET;
         zero_we     <= 1'b0;
         dir5        <= xsd_pkg::DIR_RESET;
         dir6        <= xsd_pkg::DIR_RESET;
         dir7        <= xsd_pkg::DIR_RESET;
         phase_start <= 1'b1;
      end else begin
         phase       <= next_phase;
         op          <= next_op;
         operand     <= next_operand;
         result      <= next_result;
         dest        <= next_dest;
         file_addr   <= next_file_addr;
         file_re     <= next_file_re;
         file_we     <= next_file_we;
         file_wdata  <= next_file_wdata;
         w_reg       <= next_w_reg;
         zero_flag   <= next_zero_flag;
         zero_we     <= next_zero_we;
         dir5        <= next_dir5;
         dir6        <= next_dir6;
         dir7        <= next_dir7;
         phase_start <= next_phase_start;
      end
   end

endmodule

// >>> bench/xor_exec_chk_props.sv
// checker: phase timing and side effects of the execute block
// assumes it is bound onto xor_swap_direction_load_op_exec, one clock domain
`timescale 1ns/10ps
module xor_exec_chk (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [13:0] insn,
   input wire logic [7:0]  file_rdata,
   input wire logic        phase_start,
   input wire logic [6:0]  file_addr,
   input wire logic        file_re,
   input wire logic        file_we,
   input wire logic [7:0]  file_wdata,
   input wire logic [7:0]  w_reg,
   input wire logic        zero_flag,
   input wire logic        zero_we,
   input wire logic [7:0]  dir5,
   input wire logic [7:0]  dir6,
   input wire logic [7:0]  dir7
);
   // one clock; reset masks every check
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // decode phase recurs every four clocks
   AST_CADENCE: assert property (
      phase_start |=> !phase_start [*3] ##1 phase_start)
      else $error("phase cadence broken");
   AST_READ_PHASE: assert property (file_re |-> $past(phase_start))
      else $error("read strobe outside read phase");
   AST_WR_AFTER_RD: assert property (file_we |-> $past(file_re, 3))
      else $error("file write without read");
   AST_WR_NOT_DIR: assert property (
      file_we |-> file_addr < 7'h05 || file_addr > 7'h07)
      else $error("file bus written for direction register");
   AST_ZERO_OF_FILE: assert property (
      zero_we && file_we |-> zero_flag == (file_wdata == 8'h00))
      else $error("zero flag wrong for written result");
   AST_FLAG_ONLY_XOR: assert property (
      $changed(zero_flag) |-> zero_we)
      else $error("zero flag changed without update");
   AST_W_AT_WRITE: assert property (
      $changed(w_reg) |-> phase_start && !file_we)
      else $error("working register changed out of turn");
   AST_DIR_AT_WRITE: assert property (
      $changed({dir5, dir6, dir7}) |-> phase_start && !file_we)
      else $error("direction register changed out of turn");
   // main scenarios reached
   COV_FILE_WR: cover property (file_we);
   COV_ZERO_SET: cover property (zero_we && zero_flag);
   COV_DIR_CHG: cover property ($changed(dir7));
endmodule
bind xor_swap_direction_load_op_exec xor_exec_chk xor_exec_chk_inst (
   .clk(clk), .sys_rst(sys_rst), .insn(insn), .file_rdata(file_rdata),
   .phase_start(phase_start), .file_addr(file_addr), .file_re(file_re),
   .file_we(file_we), .file_wdata(file_wdata), .w_reg(w_reg),
   .zero_flag(zero_flag), .zero_we(zero_we), .dir5(dir5), .dir6(dir6),
   .dir7(dir7));

// >>> bench/xor_swap_direction_load_op_exec_tb.sv
// testbench: runs each instruction kind and checks the results
// assumes the execute block alone; the bench answers file reads
`timescale 1ns/10ps
module xor_swap_direction_load_op_exec_tb;
   logic        clk = 1'b0;            // core clock, 20 ns
   logic        sys_rst = 1'b1;        // held 6 cycles
   logic [13:0] insn = 14'h0000;       // instruction word
   logic [7:0]  file_rdata = 8'h00;    // bench read answer
   logic        phase_start, file_re, file_we, zero_flag, zero_we;
   logic [6:0]  file_addr;
   logic [7:0]  file_wdata, w_reg, dir5, dir6, dir7;
   logic [7:0]  ew = xsd_pkg::W_RESET; // expected working register
   logic [7:0]  d5 = xsd_pkg::DIR_RESET, d6 = xsd_pkg::DIR_RESET;
   logic [7:0]  d7 = xsd_pkg::DIR_RESET;
   logic        ez = xsd_pkg::ZERO_RESET;
   int          n_fail = 0, check_count = 0;
   always #10 clk = ~clk;
   xor_swap_direction_load_op_exec xor_swap_direction_load_op_exec_inst (
      .clk(clk), .sys_rst(sys_rst), .insn(insn), .file_rdata(file_rdata),
      .phase_start(phase_start), .file_addr(file_addr), .file_re(file_re),
      .file_we(file_we), .file_wdata(file_wdata), .w_reg(w_reg),
      .zero_flag(zero_flag), .zero_we(zero_we), .dir5(dir5), .dir6(dir6),
      .dir7(dir7));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] xv, gv);
      check_count++;
      if (gv !== xv) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, xv, gv);
      end
   endtask
   function automatic logic [13:0] ins(input logic [5:0] op,
                                       input logic [7:0] lo);
      return {op, lo};
   endfunction
   // one instruction, results checked in phase 0, then a no-op gap
   task automatic run(input logic [13:0] i, input logic [7:0] rd, fwd,
                      input logic [1:0] fl);
      logic fop;                      // file read expected
      fop = (i[13:8] == xsd_pkg::XOR_FILE_OP6) ||
            (i[13:8] == xsd_pkg::SWAP_OP6);
      insn <= i;
      file_rdata <= rd;
      @(posedge clk);
      @(negedge clk);
      chk("phase_start_rd", 8'h00, {7'h00, phase_start});
      chk("file_re", {7'h00, fop}, {7'h00, file_re});
      if (fop) chk("file_addr", {1'b0, i[6:0]}, {1'b0, file_addr});
      @(posedge clk);
      file_rdata <= ~rd;
      repeat (2) @(posedge clk);
      insn <= 14'h0000;
      @(negedge clk);
      chk("w_reg", ew, w_reg);
      chk("zero_flag", {7'h00, ez}, {7'h00, zero_flag});
      chk("file_we", {7'h00, fl[1]}, {7'h00, file_we});
      chk("zero_we", {7'h00, fl[0]}, {7'h00, zero_we});
      if (fl[1]) chk("file_wdata", fwd, file_wdata);
      chk("dirs", d5 ^ d6 ^ d7, dir5 ^ dir6 ^ dir7);
      chk("dir6", d6, dir6);
      chk("dir5", d5, dir5);
      chk("dir7", d7, dir7);
      chk("phase_start", 8'h01, {7'h00, phase_start});
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_lit();
      ew = 8'hb5;
      run(ins(xsd_pkg::XOR_LIT_OP6, 8'hb5), 8'h00, 8'h00, 2'b01);
      ew = 8'h00;
      ez = 1'b1;
      run(ins(xsd_pkg::XOR_LIT_OP6, 8'hb5), 8'h3c, 8'h00, 2'b01);
   endtask
   task automatic t_file();
      ew = 8'hb5;
      ez = 1'b0;
      run(ins(xsd_pkg::XOR_LIT_OP6, 8'hb5), 8'h00, 8'h00, 2'b01);
      run(ins(xsd_pkg::XOR_FILE_OP6, 8'ha0), 8'haf, 8'h1a, 2'b11);
      ew = 8'h00;
      ez = 1'b1;
      run(ins(xsd_pkg::XOR_FILE_OP6, 8'h21), 8'hb5, 8'h00, 2'b01);
   endtask
   task automatic t_swap();
      ew = 8'h5a;
      run(ins(xsd_pkg::SWAP_OP6, 8'h30), 8'ha5, 8'h00, 2'b00);
      run(ins(xsd_pkg::SWAP_OP6, 8'hb1), 8'h3c, 8'hc3, 2'b10);
   endtask
   task automatic t_dir();
      d5 = 8'h5a;
      run({xsd_pkg::DIR_LOAD_PAT, 3'h5}, 8'h00, 8'h00, 2'b00);
      ew = 8'ha5;
      ez = 1'b0;
      run(ins(xsd_pkg::XOR_LIT_OP6, 8'hff), 8'h00, 8'h00, 2'b01);
      d7 = 8'ha5;
      run({xsd_pkg::DIR_LOAD_PAT, 3'h7}, 8'h00, 8'h00, 2'b00);
      run({xsd_pkg::DIR_LOAD_PAT, 3'h4}, 8'h00, 8'h00, 2'b00);
   endtask
   task automatic t_dir_file();
      d7 = 8'h00;
      ez = 1'b1;
      run(ins(xsd_pkg::XOR_FILE_OP6, 8'h87), 8'h33, 8'h00, 2'b01);
      ew = 8'hff;
      ez = 1'b0;
      run(ins(xsd_pkg::XOR_FILE_OP6, 8'h05), 8'h33, 8'h00, 2'b01);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // watchdog: the run needs about 2.2 us
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_lit();
      t_file();
      t_swap();
      t_dir();
      t_dir_file();
      conclude();
   end
endmodule
